// File: include/bbd_pkg.sv
// constants for the branch and bit instruction decoder
package bbd_pkg;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_LONG_CALL       = 8'h12;
  localparam logic [7:0] OP_LONG_JUMP       = 8'h02;
  localparam logic [7:0] OP_SHORT_REL_JUMP  = 8'h80;
  localparam logic [7:0] OP_INDEXED_JUMP    = 8'h73;
  localparam logic [7:0] OP_ACC_ZERO        = 8'h60;
  localparam logic [7:0] OP_ACC_NONZERO     = 8'h70;
  localparam logic [7:0] OP_CARRY_SET       = 8'h40;
  localparam logic [7:0] OP_CARRY_CLEAR     = 8'h50;
  localparam logic [7:0] OP_BIT_SET         = 8'h20;
  localparam logic [7:0] OP_BIT_CLEAR       = 8'h30;
  localparam logic [7:0] OP_BIT_SET_CLR     = 8'h10;
  localparam logic [7:0] OP_CMP_DIR         = 8'hB5;
  localparam logic [7:0] OP_CMP_IMM         = 8'hB4;
  localparam logic [7:0] OP_CMP_REG         = 8'hB8;
  localparam logic [7:0] OP_CMP_IND         = 8'hB6;
  localparam logic [7:0] OP_DEC_REG         = 8'hD8;
  localparam logic [7:0] OP_DEC_DIR         = 8'hD5;
  localparam logic [7:0] OP_BIT_CLR         = 8'hC2;
  localparam logic [7:0] OP_BIT_ONE         = 8'hD2;
  localparam logic [7:0] OP_BIT_INV         = 8'hB2;
  localparam logic [7:0] OP_AND_C           = 8'h82;
  localparam logic [7:0] OP_OR_C            = 8'h72;
  localparam logic [7:0] OP_ANDN_C          = 8'hB0;
  localparam logic [7:0] OP_ORN_C           = 8'hA0;
  localparam logic [7:0] OP_MOV_TO_C        = 8'hA2;
  localparam logic [7:0] OP_MOV_FROM_C      = 8'h92;
  localparam logic [7:0] OP_AND_DIR_A       = 8'h52;
  localparam logic [7:0] OP_AND_DIR_IMM     = 8'h53;
  localparam logic [7:0] OP_OR_DIR_A        = 8'h42;
  localparam logic [7:0] OP_OR_DIR_IMM      = 8'h43;
  localparam logic [7:0] OP_XOR_DIR_A       = 8'h62;
  localparam logic [7:0] OP_XOR_DIR_IMM     = 8'h63;
  localparam logic [7:0] OP_INC_DIR         = 8'h05;
  localparam logic [7:0] OP_INC_IND         = 8'h06;
  localparam logic [7:0] OP_DEC_DIR1        = 8'h15;
  localparam logic [7:0] OP_DEC_IND         = 8'h16;
  // abs call/jump: low five bits, page bits in [7:5]
  localparam logic [4:0] OP_ABS_CALL_LO     = 5'h11;
  localparam logic [4:0] OP_ABS_JUMP_LO     = 5'h01;
  // masks for register / indirect ranges
  localparam logic [7:0] MASK_REG           = 8'hF8;
  localparam logic [7:0] MASK_IND           = 8'hFE;

  // ----------------------------------------------------------------
  // base cycle counts and lengths
  // ----------------------------------------------------------------
  localparam logic [2:0] CYC_2 = 3'h2;
  localparam logic [2:0] CYC_3 = 3'h3;
  localparam logic [2:0] CYC_4 = 3'h4;
  localparam logic [2:0] CYC_5 = 3'h5;
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [2:0] CYC_ONE = 3'h1;

  // ----------------------------------------------------------------
  // page layout and bit operation codes
  // ----------------------------------------------------------------
  localparam int PAGE_BITS = 11;

  typedef enum logic [2:0] {
    BBD_BIT_NONE, BBD_BIT_CLR, BBD_BIT_SET, BBD_BIT_INV,
    BBD_BIT_FROM_C
  } bbd_bitop_type;

  typedef enum logic [2:0] {
    BBD_C_NONE, BBD_C_AND, BBD_C_OR, BBD_C_ANDN, BBD_C_ORN, BBD_C_MOV
  } bbd_cop_type;

endpackage

// File: src/bbd_target.sv
// branch target arithmetic
`timescale 1ns/1ps

module bbd_target
(
  input  wire logic [15:0] nextPc,
  input  wire logic [7:0]  relOffset,
  input  wire logic [7:0]  addrLo,
  input  wire logic [7:0]  addrHi,
  input  wire logic [2:0]  pageBits,
  input  wire logic [7:0]  acc,
  input  wire logic [15:0] dataPointer,
  output logic      [15:0] relTarget,
  output logic      [15:0] absTarget,
  output logic      [15:0] longTarget,
  output logic      [15:0] indexTarget
);

  always_comb
  begin
    relTarget   = nextPc + {{8{relOffset[7]}}, relOffset};
    absTarget   = {nextPc[15:bbd_pkg::PAGE_BITS], pageBits, addrLo};
    longTarget  = {addrHi, addrLo};
    indexTarget = dataPointer + {8'h00, acc};
  end

endmodule // bbd_target

// File: src/bbd_decoder.sv
// decode and cycle timing for branch, bit and rmw instructions
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/1ps

module bbd_decoder
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  operand1,
  input  wire logic [7:0]  operand2,
  input  wire logic [15:0] instrPc,
  input  wire logic [7:0]  acc,
  input  wire logic        carry,
  input  wire logic [15:0] dataPointer,
  input  wire logic        bitValue,
  input  wire logic [7:0]  compareValue,
  input  wire logic [7:0]  decValue,
  input  wire logic        portTarget,
  output logic             busy,
  output logic             fetchNext,
  output logic [15:0]      newPc,
  output logic [1:0]       instrLength,
  output logic [2:0]       cycleCount,
  output logic             branchTaken,
  output logic             readLatch,
  output logic             rmwClass,
  output logic             bitWrite,
  output logic             bitResult,
  output logic             carryWrite,
  output logic             carryResult,
  output logic             known
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic inRange(input logic [7:0] op,
                                   input logic [7:0] base,
                                   input logic [7:0] mask);
    return (op & mask) == base;
  endfunction

  function automatic logic isAbs(input logic [7:0] op);
    return op[4:0] == bbd_pkg::OP_ABS_CALL_LO ||
           op[4:0] == bbd_pkg::OP_ABS_JUMP_LO;
  endfunction

  typedef enum logic { BBD_IDLE, BBD_EXEC } bbd_state_type;

  bbd_state_type state;
  bbd_state_type next_state;
  logic [2:0]    remain;
  logic [2:0]    next_remain;

  logic [15:0] nextAddr;
  logic [15:0] relTarget;
  logic [15:0] absTarget;
  logic [15:0] longTarget;
  logic [15:0] indexTarget;

  logic [1:0]    decLen;
  logic [2:0]    decCyc;
  logic          decCond;
  logic          decUncond;
  logic          decKnown;
  logic          decRmw;
  logic [15:0]   decTarget;
  logic          decJump;
  bbd_pkg::bbd_bitop_type decBitOp;
  bbd_pkg::bbd_cop_type   decCop;
  logic [7:0]    decMinus;

  logic [1:0]  next_instrLength;
  logic [2:0]  next_cycleCount;
  logic [15:0] next_newPc;
  logic        next_branchTaken;
  logic        next_readLatch;
  logic        next_rmwClass;
  logic        next_bitWrite;
  logic        next_bitResult;
  logic        next_carryWrite;
  logic        next_carryResult;
  logic        next_known;
  logic        next_fetchNext;
  logic        next_busy;
  logic [2:0]  total;

  always_comb
  begin
    nextAddr = instrPc + {14'h0000, decLen};
  end

  // target picked from the opcode alone, so no loop through the length
  always_comb
  begin
    longTarget = {operand1, operand2};
    decTarget  = relTarget;
    if (isAbs(opcode))
      decTarget = absTarget;
    else if (opcode == bbd_pkg::OP_LONG_CALL ||
             opcode == bbd_pkg::OP_LONG_JUMP)
      decTarget = longTarget;
    else if (opcode == bbd_pkg::OP_INDEXED_JUMP)
      decTarget = indexTarget;
  end

  bbd_target targetCalc
  (
    .nextPc      (nextAddr),
    .relOffset   (decCond && decLen == bbd_pkg::LEN_3 ? operand2
                                                     : operand1),
    .addrLo      (operand1),
    .addrHi      (operand1),
    .pageBits    (opcode[7:5]),
    .acc         (acc),
    .dataPointer (dataPointer),
    .relTarget   (relTarget),
    .absTarget   (absTarget),
    .longTarget  (),
    .indexTarget (indexTarget)
  );

  // ----------------------------------------------------------------
  // opcode decode
  // ----------------------------------------------------------------
  always_comb
  begin
    decLen    = bbd_pkg::LEN_1;
    decCyc    = bbd_pkg::CYC_ONE;
    decCond   = 1'b0;
    decUncond = 1'b0;
    decKnown  = 1'b1;
    decRmw    = 1'b0;
    decJump   = 1'b0;
    decBitOp  = bbd_pkg::BBD_BIT_NONE;
    decCop    = bbd_pkg::BBD_C_NONE;
    decMinus  = decValue - 8'h01;
    if (isAbs(opcode))
    begin
      decLen = bbd_pkg::LEN_2;
      decCyc = bbd_pkg::CYC_3;
      decUncond = 1'b1;
    end
    else
    begin
      case (opcode)
        bbd_pkg::OP_LONG_CALL, bbd_pkg::OP_LONG_JUMP:
        begin
          decLen = bbd_pkg::LEN_3;
          decCyc = bbd_pkg::CYC_4;
          decUncond = 1'b1;
        end
        bbd_pkg::OP_SHORT_REL_JUMP:
        begin
          decLen = bbd_pkg::LEN_2;
          decCyc = bbd_pkg::CYC_4;
          decUncond = 1'b1;
        end
        bbd_pkg::OP_INDEXED_JUMP:
        begin
          decCyc = bbd_pkg::CYC_3;
          decJump = 1'b1;
        end
        bbd_pkg::OP_ACC_ZERO, bbd_pkg::OP_ACC_NONZERO:
        begin
          decLen = bbd_pkg::LEN_2;
          decCyc = bbd_pkg::CYC_3;
          decJump = (acc == 8'h00) == (opcode == bbd_pkg::OP_ACC_ZERO);
          decCond = 1'b1;
        end
        bbd_pkg::OP_CARRY_SET, bbd_pkg::OP_CARRY_CLEAR:
        begin
          decLen = bbd_pkg::LEN_2;
          decCyc = bbd_pkg::CYC_3;
          decJump = carry == (opcode == bbd_pkg::OP_CARRY_SET);
          decCond = 1'b1;
        end
        bbd_pkg::OP_BIT_SET, bbd_pkg::OP_BIT_CLEAR:
        begin
          decLen = bbd_pkg::LEN_3;
          decCyc = bbd_pkg::CYC_4;
          decJump = bitValue == (opcode == bbd_pkg::OP_BIT_SET);
          decCond = 1'b1;
        end
        bbd_pkg::OP_BIT_SET_CLR:
        begin
          decLen = bbd_pkg::LEN_3;
          decCyc = bbd_pkg::CYC_4;
          decJump = bitValue;
          decCond = 1'b1;
          decRmw = 1'b1;
          if (bitValue)
            decBitOp = bbd_pkg::BBD_BIT_CLR;
        end
        bbd_pkg::OP_CMP_DIR, bbd_pkg::OP_CMP_IMM:
        begin
          decLen = bbd_pkg::LEN_3;
          decCyc = bbd_pkg::CYC_4;
          decJump = acc != compareValue;
          decCond = 1'b1;
        end
        bbd_pkg::OP_DEC_DIR:
        begin
          decLen = bbd_pkg::LEN_3;
          decCyc = bbd_pkg::CYC_4;
          decJump = decMinus != 8'h00;
          decCond = 1'b1;
          decRmw = 1'b1;
        end
        bbd_pkg::OP_BIT_CLR, bbd_pkg::OP_BIT_ONE,
        bbd_pkg::OP_BIT_INV, bbd_pkg::OP_MOV_FROM_C:
        begin
          decLen = bbd_pkg::LEN_2;
          decCyc = bbd_pkg::CYC_3;
          decRmw = 1'b1;
          case (opcode)
            bbd_pkg::OP_BIT_CLR:  decBitOp = bbd_pkg::BBD_BIT_CLR;
            bbd_pkg::OP_BIT_ONE:  decBitOp = bbd_pkg::BBD_BIT_SET;
            bbd_pkg::OP_BIT_INV:  decBitOp = bbd_pkg::BBD_BIT_INV;
            default:              decBitOp = bbd_pkg::BBD_BIT_FROM_C;
          endcase
        end
        bbd_pkg::OP_AND_C, bbd_pkg::OP_OR_C, bbd_pkg::OP_ANDN_C,
        bbd_pkg::OP_ORN_C, bbd_pkg::OP_MOV_TO_C:
        begin
          decLen = bbd_pkg::LEN_2;
          decCyc = bbd_pkg::CYC_2;
          case (opcode)
            bbd_pkg::OP_AND_C:  decCop = bbd_pkg::BBD_C_AND;
            bbd_pkg::OP_OR_C:   decCop = bbd_pkg::BBD_C_OR;
            bbd_pkg::OP_ANDN_C: decCop = bbd_pkg::BBD_C_ANDN;
            bbd_pkg::OP_ORN_C:  decCop = bbd_pkg::BBD_C_ORN;
            default:            decCop = bbd_pkg::BBD_C_MOV;
          endcase
        end
        bbd_pkg::OP_AND_DIR_A, bbd_pkg::OP_OR_DIR_A,
        bbd_pkg::OP_XOR_DIR_A, bbd_pkg::OP_INC_DIR,
        bbd_pkg::OP_DEC_DIR1:
        begin
          decLen = bbd_pkg::LEN_2;
          decCyc = bbd_pkg::CYC_3;
          decRmw = 1'b1;
        end
        bbd_pkg::OP_AND_DIR_IMM, bbd_pkg::OP_OR_DIR_IMM,
        bbd_pkg::OP_XOR_DIR_IMM:
        begin
          decLen = bbd_pkg::LEN_3;
          decCyc = bbd_pkg::CYC_4;
          decRmw = 1'b1;
        end
        default:
        begin
          if (inRange(opcode, bbd_pkg::OP_CMP_REG, bbd_pkg::MASK_REG))
          begin
            decLen = bbd_pkg::LEN_3;
            decCyc = bbd_pkg::CYC_4;
            decJump = acc != compareValue;
            decCond = 1'b1;
          end
          else if (inRange(opcode, bbd_pkg::OP_CMP_IND,
                           bbd_pkg::MASK_IND))
          begin
            decLen = bbd_pkg::LEN_3;
            decCyc = bbd_pkg::CYC_5;
            decJump = acc != compareValue;
            decCond = 1'b1;
          end
          else if (inRange(opcode, bbd_pkg::OP_DEC_REG,
                           bbd_pkg::MASK_REG))
          begin
            decLen = bbd_pkg::LEN_2;
            decCyc = bbd_pkg::CYC_3;
            decJump = decMinus != 8'h00;
            decCond = 1'b1;
          end
          else if (inRange(opcode, bbd_pkg::OP_INC_IND,
                           bbd_pkg::MASK_IND) ||
                   inRange(opcode, bbd_pkg::OP_DEC_IND,
                           bbd_pkg::MASK_IND))
          begin
            decCyc = bbd_pkg::CYC_3;
            decRmw = 1'b1;
          end
          else
            decKnown = 1'b0;
        end
      endcase
    end
    if (decUncond)
      decJump = 1'b1;
  end

  // ----------------------------------------------------------------
  // result and cycle count
  // ----------------------------------------------------------------
  always_comb
  begin
    total = decCyc;
    if (decCond && decJump)
      total = decCyc + bbd_pkg::CYC_ONE;
    if (decUncond && decTarget == nextAddr)
      total = decCyc - bbd_pkg::CYC_ONE;
    next_state       = state;
    next_remain      = remain;
    next_instrLength = instrLength;
    next_cycleCount  = cycleCount;
    next_newPc       = newPc;
    next_branchTaken = branchTaken;
    next_readLatch   = 1'b0;
    next_rmwClass    = rmwClass;
    next_bitWrite    = 1'b0;
    next_bitResult   = bitResult;
    next_carryWrite  = 1'b0;
    next_carryResult = carryResult;
    next_known       = known;
    next_fetchNext   = 1'b0;
    next_busy        = busy;
    case (state)
      BBD_IDLE:
      begin
        if (start)
        begin
          next_instrLength = decLen;
          next_cycleCount  = total;
          next_newPc       = decJump ? decTarget : nextAddr;
          next_branchTaken = decJump;
          next_rmwClass    = decRmw;
          next_readLatch   = decRmw && portTarget;
          next_known       = decKnown;
          next_bitWrite    = decBitOp != bbd_pkg::BBD_BIT_NONE;
          case (decBitOp)
            bbd_pkg::BBD_BIT_SET:    next_bitResult = 1'b1;
            bbd_pkg::BBD_BIT_INV:    next_bitResult = ~bitValue;
            bbd_pkg::BBD_BIT_FROM_C: next_bitResult = carry;
            default:                 next_bitResult = 1'b0;
          endcase
          next_carryWrite  = decCop != bbd_pkg::BBD_C_NONE;
          case (decCop)
            bbd_pkg::BBD_C_AND:  next_carryResult = carry & bitValue;
            bbd_pkg::BBD_C_OR:   next_carryResult = carry | bitValue;
            bbd_pkg::BBD_C_ANDN: next_carryResult = carry & ~bitValue;
            bbd_pkg::BBD_C_ORN:  next_carryResult = carry | ~bitValue;
            bbd_pkg::BBD_C_MOV:  next_carryResult = bitValue;
            default:             next_carryResult = carry;
          endcase
          if (total == bbd_pkg::CYC_ONE)
            next_fetchNext = 1'b1;
          else
          begin
            next_remain = total - bbd_pkg::CYC_ONE;
            next_busy   = 1'b1;
            next_state  = BBD_EXEC;
          end
        end
      end
      BBD_EXEC:
      begin
        next_remain = remain - bbd_pkg::CYC_ONE;
        if (remain == bbd_pkg::CYC_ONE)
        begin
          next_fetchNext = 1'b1;
          next_busy      = 1'b0;
          next_state     = BBD_IDLE;
        end
      end
      default:
        next_state = BBD_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state       <= BBD_IDLE;
      remain      <= 3'h0;
      instrLength <= 2'h0;
      cycleCount  <= 3'h0;
      newPc       <= 16'h0000;
      branchTaken <= 1'b0;
      readLatch   <= 1'b0;
      rmwClass    <= 1'b0;
      bitWrite    <= 1'b0;
      bitResult   <= 1'b0;
      carryWrite  <= 1'b0;
      carryResult <= 1'b0;
      known       <= 1'b0;
      fetchNext   <= 1'b0;
      busy        <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      remain      <= next_remain;
      instrLength <= next_instrLength;
      cycleCount  <= next_cycleCount;
      newPc       <= next_newPc;
      branchTaken <= next_branchTaken;
      readLatch   <= next_readLatch;
      rmwClass    <= next_rmwClass;
      bitWrite    <= next_bitWrite;
      bitResult   <= next_bitResult;
      carryWrite  <= next_carryWrite;
      carryResult <= next_carryResult;
      known       <= next_known;
      fetchNext   <= next_fetchNext;
      busy        <= next_busy;
    end
  end

endmodule // bbd_decoder

// File: test/bbd_sfr_model.sv
// far-side model: addressed bit and carry flag storage
`timescale 1ns/1ps

module bbd_sfr_model
(
  input  wire logic clk,
  input  wire logic presetEn,
  input  wire logic presetBit,
  input  wire logic presetCarry,
  input  wire logic bitWrite,
  input  wire logic bitResult,
  input  wire logic carryWrite,
  input  wire logic carryResult,
  output logic      bitLevel,
  output logic      carryFlag
);
  logic bitMem;
  logic carryMem;

  always_ff @(posedge clk)
  begin
    if (presetEn)
    begin
      bitMem   <= presetBit;
      carryMem <= presetCarry;
    end
    else
    begin
      if (bitWrite)
        bitMem <= bitResult;
      if (carryWrite)
        carryMem <= carryResult;
    end
  end

  // a preset shows at once so the bench can load state with a start
  assign bitLevel  = presetEn ? presetBit : bitMem;
  assign carryFlag = presetEn ? presetCarry : carryMem;
endmodule // bbd_sfr_model

// File: test/bbd_decoder_chk.sv
// concurrent checks on the decoder ports
`timescale 1ns/1ps

module bbd_decoder_chk
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        start,
  input wire logic [7:0]  opcode,
  input wire logic [7:0]  operand1,
  input wire logic [7:0]  operand2,
  input wire logic [15:0] instrPc,
  input wire logic [7:0]  acc,
  input wire logic [15:0] dataPointer,
  input wire logic        bitValue,
  input wire logic [7:0]  decValue,
  input wire logic        portTarget,
  input wire logic        busy,
  input wire logic        fetchNext,
  input wire logic [15:0] newPc,
  input wire logic [2:0]  cycleCount,
  input wire logic        branchTaken,
  input wire logic        readLatch,
  input wire logic        rmwClass,
  input wire logic        bitWrite,
  input wire logic        bitResult,
  input wire logic        carryWrite,
  input wire logic        carryResult
);
  // ------
  // cycles since the last taken start
  // ------
  logic       taken;
  logic [2:0] cnt;
  logic [2:0] next_cnt;

  assign taken = start && !busy;

  always_comb
  begin
    next_cnt = (cnt == 3'h7) ? cnt : cnt + 3'h1;
    if (taken)
      next_cnt = 3'h1;
  end

  always_ff @(posedge clk)
    cnt <= rst_n ? next_cnt : 3'h0;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ------
  // assertions
  // ------
  a_fetch_count: assert property (fetchNext |-> cnt == cycleCount)
    else $error("fetch pulse off its cycle count");
  a_take_answers: assert property (taken |=> busy || fetchNext)
    else $error("taken start gave no busy or fetch");
  a_busy_early: assert property (busy |-> !fetchNext && cnt < cycleCount)
    else $error("busy overlaps the last cycle");
  a_indexed_jump: assert property (taken && opcode == 8'h73 |=>
    newPc == $past(dataPointer) + $past(acc) && cycleCount == 3'h3)
    else $error("indexed jump target or count wrong");
  a_acc_zero_taken: assert property (taken && opcode == 8'h60 &&
    acc == 8'h00 |=> branchTaken && cycleCount == 3'h4 ##3 fetchNext)
    else $error("zero branch not taken in four cycles");
  a_acc_nonzero_skip: assert property (taken && opcode == 8'h70 &&
    acc == 8'h00 |=> !branchTaken && newPc == $past(instrPc) + 16'h0002)
    else $error("nonzero branch taken on zero");
  a_bit_set_write: assert property (taken && opcode == 8'hD2 |=>
    bitWrite && bitResult && readLatch == $past(portTarget))
    else $error("bit set write or latch read wrong");
  a_carry_copy: assert property (taken && opcode == 8'hA2 |=>
    carryWrite && carryResult == $past(bitValue) && !bitWrite)
    else $error("bit to carry copy wrong");
  a_dec_direct_stop: assert property (taken && opcode == 8'hD5 &&
    decValue == 8'h01 |=> rmwClass && !branchTaken && cycleCount == 3'h4)
    else $error("direct decrement branch wrong at one");
  a_long_jump_next: assert property (taken && opcode == 8'h02 &&
    {operand1, operand2} == instrPc + 16'h0003 |=> cycleCount == 3'h3)
    else $error("long jump to next address not shortened");
  a_bit_test_clear: assert property (taken && opcode == 8'h10 &&
    bitValue |=> bitWrite && !bitResult && branchTaken && cycleCount == 3'h5)
    else $error("test and clear branch wrong");
  a_cmp_ind_count: assert property (taken && opcode[7:1] == 7'h5B |=>
    cycleCount == (branchTaken ? 3'h6 : 3'h5))
    else $error("indirect compare branch count wrong");
endmodule // bbd_decoder_chk

bind bbd_decoder bbd_decoder_chk i_chk
(
  .clk(clk), .rst_n(rst_n), .start(start), .opcode(opcode),
  .operand1(operand1), .operand2(operand2), .instrPc(instrPc), .acc(acc),
  .dataPointer(dataPointer), .bitValue(bitValue), .decValue(decValue),
  .portTarget(portTarget), .busy(busy), .fetchNext(fetchNext),
  .newPc(newPc), .cycleCount(cycleCount), .branchTaken(branchTaken),
  .readLatch(readLatch), .rmwClass(rmwClass), .bitWrite(bitWrite),
  .bitResult(bitResult), .carryWrite(carryWrite), .carryResult(carryResult)
);

// File: test/bbd_decoder_tb.sv
// self-checking bench for the branch and bit decoder
`timescale 1ns/1ps

module bbd_decoder_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        start = 1'b0;
  logic [7:0]  opcode = 8'h00, operand1 = 8'h00, operand2 = 8'h00;
  logic [7:0]  acc = 8'h00, compareValue = 8'h00, decValue = 8'h00;
  logic [15:0] instrPc = 16'h0000, dataPointer = 16'h0000;
  logic        portTarget = 1'b0, presetBit = 1'b0, presetCarry = 1'b0;
  logic        presetEn = 1'b1;
  logic        carry, bitValue, busy, fetchNext, branchTaken, readLatch;
  logic        rmwClass, bitWrite, bitResult, carryWrite, carryResult, known;
  logic [15:0] newPc;
  logic [1:0]  instrLength;
  logic [2:0]  cycleCount;
  logic        mBit = 1'b0, mCarry = 1'b0;
  int          miscompares = 0;
  int          total_checks = 0;
  logic [7:0]  ops [44] = '{8'h01, 8'h11, 8'h12, 8'h02, 8'h80, 8'h73, 8'h60,
    8'h70, 8'h40, 8'h50, 8'h20, 8'h30, 8'h10, 8'hB5, 8'hB4, 8'hB8, 8'hBF,
    8'hB6, 8'hB7, 8'hD8, 8'hDF, 8'hD5, 8'hC2, 8'hD2, 8'hB2, 8'h82, 8'h72,
    8'hB0, 8'hA0, 8'hA2, 8'h92, 8'h52, 8'h53, 8'h42, 8'h43, 8'h62, 8'h63,
    8'h05, 8'h06, 8'h07, 8'h15, 8'h16, 8'h17, 8'hE4};

  bbd_decoder i_dut
  (
    .clk(clk), .rst_n(rst_n), .start(start), .opcode(opcode),
    .operand1(operand1), .operand2(operand2), .instrPc(instrPc),
    .acc(acc), .carry(carry), .dataPointer(dataPointer),
    .bitValue(bitValue), .compareValue(compareValue), .decValue(decValue),
    .portTarget(portTarget), .busy(busy), .fetchNext(fetchNext),
    .newPc(newPc), .instrLength(instrLength), .cycleCount(cycleCount),
    .branchTaken(branchTaken), .readLatch(readLatch), .rmwClass(rmwClass),
    .bitWrite(bitWrite), .bitResult(bitResult), .carryWrite(carryWrite),
    .carryResult(carryResult), .known(known)
  );

  bbd_sfr_model i_sfr
  (
    .clk(clk), .presetEn(presetEn), .presetBit(presetBit),
    .presetCarry(presetCarry), .bitWrite(bitWrite), .bitResult(bitResult),
    .carryWrite(carryWrite), .carryResult(carryResult),
    .bitLevel(bitValue), .carryFlag(carry)
  );

  always #10 clk = ~clk;

  task check(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want)
    begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one instruction: reference model, drive, compare
  task run(input logic [7:0] opIn, input logic nx);
    logic [7:0]  op, o1, o2;
    logic [15:0] tgt, seq, pc2;
    logic        b, c, tk, br, cr, cond, uj, bw, cw, read_modify_write_class, kn;
    int          len, cyc, rel, n;
    op = opIn;
    o1 = $urandom;
    o2 = $urandom;
    instrPc = $urandom;
    acc = $urandom % 4;
    compareValue = ($urandom % 2) ? acc : acc ^ 8'h5A;
    decValue = $urandom % 3;
    dataPointer = $urandom;
    portTarget = $urandom;
    presetEn = $urandom;
    presetBit = $urandom;
    presetCarry = $urandom;
    b = presetEn ? presetBit : mBit;
    c = presetEn ? presetCarry : mCarry;
    mBit = b;
    mCarry = c;
    pc2 = instrPc + 16'h0002;
    if (nx && op[3:0] == 4'h1)
      {op[7:5], o1} = pc2[10:0];
    else if (nx)
      {o1, o2} = (op == 8'h80) ? 16'h0000 : instrPc + 16'h0003;
    if (op[7:4] == 4'hB)
      o1 = compareValue;
    cond = op inside {8'h60, 8'h70, 8'h40, 8'h50, 8'h20, 8'h30, 8'h10,
      8'hB4, 8'hB5, [8'hB6:8'hBF], 8'hD5, [8'hD8:8'hDF]};
    uj = op inside {8'h12, 8'h02, 8'h80, 8'h73} || op[3:0] == 4'h1;
    cw = op inside {8'h82, 8'h72, 8'hB0, 8'hA0, 8'hA2};
    read_modify_write_class = op inside {8'h52, 8'h53, 8'h42, 8'h43, 8'h62, 8'h63, 8'h10, 8'hB2,
      8'h05, 8'h06, 8'h07, 8'h15, 8'h16, 8'h17, 8'hD5, 8'h92, 8'hC2, 8'hD2};
    kn = uj || cond || cw || read_modify_write_class;
    len = (!kn || op inside {8'h73, 8'h06, 8'h07, 8'h16, 8'h17}) ? 1 :
      (op inside {8'h12, 8'h02, 8'h53, 8'h43, 8'h63} || (cond &&
      !(op inside {8'h60, 8'h70, 8'h40, 8'h50, [8'hD8:8'hDF]}))) ? 3 : 2;
    cyc = !kn ? 1 : cw ? 2 : op inside {8'hB6, 8'hB7} ? 5 :
      (op inside {8'h12, 8'h02, 8'h80, 8'h53, 8'h43, 8'h63} ||
      (cond && len == 3)) ? 4 : 3;
    rel = $signed(len == 3 ? o2 : o1);
    seq = instrPc + len;
    tgt = (op == 8'h73) ? acc + dataPointer :
      (op inside {8'h12, 8'h02}) ? {o1, o2} :
      (op[3:0] == 4'h1) ? {pc2[15:11], op[7:5], o1} : seq + rel;
    tk = op == 8'h60 ? acc == 0 : op == 8'h70 ? acc != 0 : op == 8'h40 ? c :
      op == 8'h50 ? !c : op inside {8'h20, 8'h10} ? b : op == 8'h30 ? !b :
      op[7:4] == 4'hD ? decValue != 8'h01 : acc != compareValue;
    cyc = cyc + (cond && tk) - (uj && op != 8'h73 && tgt == seq);
    bw = op inside {8'hC2, 8'hD2, 8'hB2, 8'h92} || (op == 8'h10 && tk);
    br = op == 8'hD2 || (op == 8'hB2 && !b) || (op == 8'h92 && c);
    cr = op == 8'h82 ? c & b : op == 8'h72 ? c | b : op == 8'hB0 ? c & !b :
      op == 8'hA0 ? c | !b : b;
    opcode = op;
    operand1 = o1;
    operand2 = o2;
    start = 1'b1;
    @(posedge clk);
    #1;
    if (cyc > 1) presetEn = 1'b0;
    check(newPc, (uj || (cond && tk)) ? tgt : seq);
    check(cycleCount, cyc);
    check(instrLength, len);
    check({known, rmwClass, readLatch, bitWrite, carryWrite},
      {kn, read_modify_write_class, read_modify_write_class & portTarget, bw, cw});
    check(branchTaken, uj || (cond && tk));
    if (bw) check(bitResult, br);
    if (cw) check(carryResult, cr);
    // extra starts while busy must be ignored
    for (n = 1; fetchNext !== 1'b1 && n < 8; n++)
    begin
      start = busy;
      opcode = $urandom;
      @(posedge clk);
      #1;
    end
    if (fetchNext !== 1'b1)
    begin
      miscompares++;
      conclude();
    end
    check(n, cyc);
    if (bw) mBit = br;
    if (cw) mCarry = cr;
    check({bitValue, carry}, {mBit, mCarry});
  endtask

  initial
  begin
    void'($urandom(32'h72B9394A));
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    check({busy, fetchNext, bitWrite, carryWrite}, 16'h0000);
    repeat (6)
      foreach (ops[i])
        run(ops[i], $urandom % 2);
    conclude();
  end
endmodule // bbd_decoder_tb
